// File: design/spark_alarm_control.sv
// What this block does
// - Setpoint moves 0 to maximum in 100 V steps, one per arrow press.
// - A held arrow repeats steps, faster and faster.
// - Three-digit total count rises by one on every fault of any type.
// - Count-show button steps display through pinhole, metal, multi, gross counts.
// - Count clear button zeroes total and all four type counts.
// - Display button shows percent load, then setpoint, then electrode voltage again.
// - Voltmeter shows kilovolts with one decimal, volts divided by one hundred.
// - Fault lamp mirrors the fault alarm; latched it stays lit until reset.
// - Front button, external contact and serial command each clear the fault.
// - Fault reset clears active faults and returns relays to non-fault state.
// - Fault reset leaves all counts alone; only count clear zeroes them.
// - High-voltage lamp lit exactly while measured output exceeds 500 V.
// - Lifted cover interlock switches high voltage off.
// - High voltage only while permit input is grounded; outside keeps it closed.
// - Each defect gives one fault pulse: lamp, count and relays.
// - Fault pulse lasts while defect is in electrode, counted exactly once.
// - Latch mode: relay holds fault state until reset; voltage stays on.
// - Non-latch mode: relay active while defect present plus hold duration.
// - Latch with remove-voltage: voltage off while latched, back on at reset.
// - Remove-voltage setting has no effect in non-latch mode.
// - Close pinholes, or one long non-metal fault, count as multi-pinhole.
// - Watchdog checks fixed limits or a percentage band around setpoint.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "spark_alarm_params.svh"

module spark_alarm_control
   import spark_alarm_pkg::*;
#(
   parameter timer_type DEBOUNCE_CYCLES = timer_type'(`DEBOUNCE_MS * `CLK_KHZ),
   parameter timer_type SHOW_CYCLES = timer_type'(`SHOW_MS * `CLK_KHZ),
   parameter timer_type REPEAT_FIRST_CYCLES = timer_type'(`REPEAT_FIRST_MS * `CLK_KHZ),
   parameter timer_type REPEAT_MIN_CYCLES = timer_type'(`REPEAT_MIN_MS * `CLK_KHZ),
   parameter timer_type MS_CYCLES = timer_type'(`MS_TICK_US * `CLK_MHZ),
   parameter timer_type LONG_FAULT_CYCLES = timer_type'(`PINHOLE_MAX_US * `CLK_MHZ),
   parameter timer_type SPACING_CYCLES = timer_type'(`PIN_SPACING_US * `CLK_MHZ),
   parameter timer_type GROSS_CYCLES = timer_type'(`GROSS_US * `CLK_MHZ),
   parameter logic [15:0] MAX_SETPOINT = 16'(`SETPOINT_MAX_V)
)
(
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Panel pins and contacts.
   input wire panel_pins_type panelPins,
   // Front-end and serial inputs on this clock.
   input wire logic defectSense,
   input wire logic metalSense,
   input wire logic [14:0] measuredVolts,
   input wire logic [6:0] percentLoad,
   input wire logic serialReset,
   // Indicators and displays.
   output lamps_type lamps,
   output logic [15:0] displayValue,
   output disp_mode_type displayMode,
   output logic [9:0] countValue,
   output count_sel_type countSelect,
   output logic reducedSensitivity
);

   typedef struct packed {
      logic [8:0][2:0] sync;
      logic [8:0] clean;
      logic [8:0] cleanPrev;
      logic [8:0][25:0] bounce;
      logic [15:0] setpoint;
      timer_type repeatTimer;
      timer_type repeatInterval;
      disp_mode_type dispMode;
      timer_type dispTimer;
      logic [15:0] dispValue;
      count_sel_type cntSel;
      timer_type cntTimer;
      logic [9:0] cntValue;
      logic [9:0] total;
      logic [9:0] pinCount;
      logic [9:0] metalCount;
      logic [9:0] multiCount;
      logic [9:0] grossCount;
      logic defectPrev;
      logic metalSeen;
      timer_type defectTimer;
      timer_type gapTimer;
      logic latched;
      logic [15:0] holdMs;
      timer_type msPre;
      lamps_type lamps;
      logic [3:0] ctrl;
      logic [15:0] holdCfg;
      logic [15:0] lowLimit;
      logic [15:0] highLimit;
      logic [6:0] wdPercent;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_type;

   state_type st;
   state_type next_st;

   logic faultStart;
   logic faultEnd;
   logic resetEvent;
   logic clearEvent;
   logic latchMode;
   logic stepNow;
   logic [23:0] deviation;
   logic [23:0] band;
   timer_type halved;

   // Three-digit counts roll over from 999 to zero.
   function automatic logic [9:0] incCount(input logic [9:0] c);
      incCount = (c == `COUNT_WRAP) ? 10'h000 : c + 10'h001;
   endfunction : incCount

   // Volts to tenths of a kilovolt for the voltmeter.
   function automatic logic [15:0] toTenths(input logic [15:0] v);
      toTenths = v / 16'h0064;
   endfunction : toTenths

   // Pin events taken from debounced levels; defect edges and serialReset come straight from the inputs.
   assign faultStart = defectSense && !st.defectPrev;
   assign faultEnd = !defectSense && st.defectPrev;
   assign resetEvent = (st.clean[`PIN_RESET] && !st.cleanPrev[`PIN_RESET])
      || (!st.clean[`PIN_EXT_RESET_N] && st.cleanPrev[`PIN_EXT_RESET_N])
      || serialReset;
   assign clearEvent = st.clean[`PIN_COUNT_CLEAR] && !st.cleanPrev[`PIN_COUNT_CLEAR];
   assign latchMode = st.ctrl[`CTRL_LATCH];
   assign halved = st.repeatInterval >> 1;

   // Outputs all come straight from the state register.
   assign pready = st.pready;
   assign prdata = st.prdata;
   assign pslverr = st.pslverr;
   assign lamps = st.lamps;
   assign displayValue = st.dispValue;
   assign displayMode = st.dispMode;
   assign countValue = st.cntValue;
   assign countSelect = st.cntSel;
   assign reducedSensitivity = st.ctrl[`CTRL_REDUCED];

   // Next-state logic; nothing moves while ce is low.
   always_comb
   begin
      next_st = st;
      stepNow = 1'b0;
      deviation = 24'h00_0000;
      band = 24'h00_0000;
      if (ce)
      begin
         // Three-stage sync, then the level must hold for the debounce time.
         for (int i = 0; i < 9; i++)
         begin
            next_st.sync[i] = {st.sync[i][1:0], panelPins[i]};
            if (st.sync[i][1] != st.sync[i][2] || st.sync[i][2] == st.clean[i])
               next_st.bounce[i] = 26'h000_0000;
            else if (st.bounce[i] >= DEBOUNCE_CYCLES)
            begin
               next_st.clean[i] = st.sync[i][2];
               next_st.bounce[i] = 26'h000_0000;
            end
            else
               next_st.bounce[i] = st.bounce[i] + 26'h000_0001;
         end
         next_st.cleanPrev = st.clean;

         // Arrow stepping with a repeat interval that halves while held.
         if ((st.clean[`PIN_UP] && !st.cleanPrev[`PIN_UP])
            || (st.clean[`PIN_DOWN] && !st.cleanPrev[`PIN_DOWN]))
         begin
            stepNow = 1'b1;
            next_st.repeatTimer = REPEAT_FIRST_CYCLES;
            next_st.repeatInterval = REPEAT_FIRST_CYCLES;
         end
         else if (st.clean[`PIN_UP] || st.clean[`PIN_DOWN])
         begin
            if (st.repeatTimer <= 26'h000_0001)
            begin
               stepNow = 1'b1;
               next_st.repeatInterval = (halved < REPEAT_MIN_CYCLES) ? REPEAT_MIN_CYCLES : halved;
               next_st.repeatTimer = next_st.repeatInterval;
            end
            else
               next_st.repeatTimer = st.repeatTimer - 26'h000_0001;
         end
         // Up wins when both arrows are held; the ends clamp rather than wrap.
         if (stepNow && st.clean[`PIN_UP] && st.setpoint + `SETPOINT_STEP_V <= MAX_SETPOINT)
            next_st.setpoint = st.setpoint + `SETPOINT_STEP_V;
         else if (stepNow && !st.clean[`PIN_UP] && st.setpoint >= `SETPOINT_STEP_V)
            next_st.setpoint = st.setpoint - `SETPOINT_STEP_V;

         // Voltmeter cycle: percent load, setpoint, back to electrode voltage.
         if (st.clean[`PIN_DISPLAY] && !st.cleanPrev[`PIN_DISPLAY])
         begin
            next_st.dispMode = DISP_PERCENT;
            next_st.dispTimer = SHOW_CYCLES;
         end
         else if (st.dispMode != DISP_VOLTS)
         begin
            if (st.dispTimer <= 26'h000_0001)
            begin
               next_st.dispMode = (st.dispMode == DISP_PERCENT) ? DISP_SETPOINT : DISP_VOLTS;
               next_st.dispTimer = SHOW_CYCLES;
            end
            else
               next_st.dispTimer = st.dispTimer - 26'h000_0001;
         end
         case (st.dispMode)
            DISP_PERCENT: next_st.dispValue = {9'h000, percentLoad};
            DISP_SETPOINT: next_st.dispValue = toTenths(st.setpoint);
            DISP_VOLTS: next_st.dispValue = toTenths({1'b0, measuredVolts});
            default: next_st.dispValue = 16'h0000;
         endcase

         // Counter display walks the four type counts, then the total.
         if (st.clean[`PIN_COUNT_SHOW] && !st.cleanPrev[`PIN_COUNT_SHOW])
         begin
            next_st.cntSel = CNT_PIN;
            next_st.cntTimer = SHOW_CYCLES;
         end
         else if (st.cntSel != CNT_TOTAL)
         begin
            if (st.cntTimer <= 26'h000_0001)
            begin
               next_st.cntTimer = SHOW_CYCLES;
               case (st.cntSel)
                  CNT_PIN: next_st.cntSel = CNT_METAL;
                  CNT_METAL: next_st.cntSel = CNT_MULTI;
                  CNT_MULTI: next_st.cntSel = CNT_GROSS;
                  default: next_st.cntSel = CNT_TOTAL;
               endcase
            end
            else
               next_st.cntTimer = st.cntTimer - 26'h000_0001;
         end
         case (st.cntSel)
            CNT_PIN: next_st.cntValue = st.pinCount;
            CNT_METAL: next_st.cntValue = st.metalCount;
            CNT_MULTI: next_st.cntValue = st.multiCount;
            CNT_GROSS: next_st.cntValue = st.grossCount;
            default: next_st.cntValue = st.total;
         endcase

         // Defect tracking: one count per rising edge, typing at the falling edge.
         next_st.defectPrev = defectSense;
         if (faultStart)
         begin
            next_st.defectTimer = 26'h000_0000;
            next_st.metalSeen = metalSense;
         end
         else if (defectSense)
         begin
            if (st.defectTimer != 26'h3FF_FFFF)
               next_st.defectTimer = st.defectTimer + 26'h000_0001;
            next_st.metalSeen = st.metalSeen || metalSense;
         end
         if (st.gapTimer != 26'h3FF_FFFF)
            next_st.gapTimer = st.gapTimer + 26'h000_0001;
         // Count clear wins the old value but a same-cycle fault still counts.
         if (clearEvent)
         begin
            next_st.total = 10'h000;
            next_st.pinCount = 10'h000;
            next_st.metalCount = 10'h000;
            next_st.multiCount = 10'h000;
            next_st.grossCount = 10'h000;
         end
         if (faultStart)
            next_st.total = incCount(next_st.total);
         if (faultEnd)
         begin
            if (st.metalSeen && st.defectTimer >= GROSS_CYCLES)
               next_st.grossCount = incCount(next_st.grossCount);
            else if (st.metalSeen)
               next_st.metalCount = incCount(next_st.metalCount);
            else
            begin
               next_st.gapTimer = 26'h000_0000;
               if (st.defectTimer >= LONG_FAULT_CYCLES || st.gapTimer < SPACING_CYCLES)
                  next_st.multiCount = incCount(next_st.multiCount);
               else
                  next_st.pinCount = incCount(next_st.pinCount);
            end
         end

         // Millisecond prescaler for the non-latch hold time.
         if (st.msPre >= MS_CYCLES - 26'h000_0001)
            next_st.msPre = 26'h000_0000;
         else
            next_st.msPre = st.msPre + 26'h000_0001;
         // A reset clears the hold and the latch; a fault edge in the same cycle wins.
         if (resetEvent)
         begin
            next_st.latched = 1'b0;
            next_st.holdMs = 16'h0000;
         end
         else if (st.msPre == 26'h000_0000 && st.holdMs != 16'h0000)
            next_st.holdMs = st.holdMs - 16'h0001;
         if (faultEnd)
            next_st.holdMs = st.holdCfg;
         if (faultStart && latchMode)
            next_st.latched = 1'b1;
         if (!latchMode)
            next_st.latched = 1'b0;

         // Relay and lamp drive; the lamp mirrors the relay.
         if (latchMode)
            next_st.lamps.faultRelay = st.latched;
         else
            next_st.lamps.faultRelay = defectSense || st.defectPrev
               || st.holdMs != 16'h0000; // The prior sample covers the cycle the hold loads.
         next_st.lamps.faultLamp = next_st.lamps.faultRelay;
         next_st.lamps.hvOnLamp = measuredVolts > `HV_LAMP_V;
         // Remove-voltage only matters while a latch is held, so non-latch ignores it.
         next_st.lamps.hvEnable = !st.clean[`PIN_PERMIT_N]
            && !st.clean[`PIN_COVER]
            && !(latchMode && st.ctrl[`CTRL_REMOVE] && st.latched);

         // Watchdog against fixed limits or a percent band of the setpoint.
         deviation = ({1'b0, measuredVolts} > st.setpoint)
            ? 24'({1'b0, measuredVolts} - st.setpoint) * 24'h00_0064
            : 24'(st.setpoint - {1'b0, measuredVolts}) * 24'h00_0064;
         band = 24'(st.wdPercent) * 24'(st.setpoint);
         if (!st.lamps.hvEnable)
            next_st.lamps.watchdogAlarm = 1'b0;
         else if (st.ctrl[`CTRL_WD_PERCENT])
            next_st.lamps.watchdogAlarm = deviation > band;
         else
            next_st.lamps.watchdogAlarm = {1'b0, measuredVolts} < st.lowLimit
               || {1'b0, measuredVolts} > st.highLimit;

         // APB: one wait state, so read data is registered before pready.
         next_st.pready = 1'b0;
         next_st.pslverr = 1'b0;
         if (psel && penable && !st.pready)
         begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0000_0000;
            case (paddr)
               `REG_CTRL: next_st.prdata = {28'h000_0000, st.ctrl};
               `REG_HOLD: next_st.prdata = {16'h0000, st.holdCfg};
               `REG_LIMITS: next_st.prdata = {st.highLimit, st.lowLimit};
               `REG_PERCENT: next_st.prdata = {25'h000_0000, st.wdPercent};
               `REG_STATUS: next_st.prdata = {26'h000_0000, defectSense, st.latched,
                  st.lamps.faultRelay, st.lamps.hvEnable, st.lamps.hvOnLamp,
                  st.lamps.watchdogAlarm};
               `REG_TOTAL: next_st.prdata = {22'h00_0000, st.total};
               `REG_TYPES_A: next_st.prdata = {6'h00, st.metalCount, 6'h00, st.pinCount};
               `REG_TYPES_B: next_st.prdata = {6'h00, st.grossCount, 6'h00, st.multiCount};
               `REG_SETPOINT: next_st.prdata = {16'h0000, st.setpoint};
               default: next_st.pslverr = 1'b1;
            endcase
         end
         if (psel && penable && st.pready && pwrite)
         begin
            case (paddr)
               `REG_CTRL: next_st.ctrl = pwdata[3:0];
               `REG_HOLD: next_st.holdCfg = pwdata[15:0];
               `REG_LIMITS:
               begin
                  next_st.lowLimit = pwdata[15:0];
                  next_st.highLimit = pwdata[31:16];
               end
               `REG_PERCENT: next_st.wdPercent = pwdata[6:0];
               default: next_st.ctrl = st.ctrl;
            endcase
         end
      end
   end

   // State register; reset loads constants only.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
         st.holdCfg <= `HOLD_RESET;
         st.highLimit <= `HIGH_LIMIT_RESET;
         st.wdPercent <= `PERCENT_RESET;
         st.gapTimer <= 26'h3FF_FFFF;
         st.clean[`PIN_EXT_RESET_N] <= 1'b1;
         st.cleanPrev[`PIN_EXT_RESET_N] <= 1'b1;
         st.clean[`PIN_PERMIT_N] <= 1'b1;
         st.cleanPrev[`PIN_PERMIT_N] <= 1'b1;
      end
      else
         st <= next_st;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   cover_hv_off_a: assert property (ce && st.clean[`PIN_COVER] |=> !lamps.hvEnable)
      else $error("High voltage on with cover lifted.");

   permit_hv_off_a: assert property (ce && st.clean[`PIN_PERMIT_N] |=> !lamps.hvEnable)
      else $error("High voltage on without permit.");

   remove_voltage_a: assert property (ce && latchMode && st.ctrl[`CTRL_REMOVE] && st.latched
      |=> !lamps.hvEnable)
      else $error("High voltage kept on while latched with remove-voltage.");

   hv_lamp_a: assert property (ce |=> lamps.hvOnLamp == ($past(measuredVolts) > 15'h01F4))
      else $error("High-voltage lamp disagrees with measured level.");

   count_once_a: assert property (ce && faultStart && !clearEvent
      |=> st.total == incCount($past(st.total))
      ##1 ($stable(st.total) || $past(clearEvent)))
      else $error("Fault not counted exactly once.");

   reset_keeps_a: assert property (ce && resetEvent && !clearEvent && !faultStart
      |=> $stable(st.total) && $stable(st.pinCount) && $stable(st.multiCount))
      else $error("Fault reset altered a count.");

   clear_counts_a: assert property (ce && clearEvent && !faultStart && !faultEnd
      |=> st.total == 10'h000 && st.grossCount == 10'h000)
      else $error("Count clear left a count standing.");

   latch_hold_a: assert property (ce && latchMode && st.latched && !resetEvent
      && $stable(st.ctrl) |=> st.latched ##1 (!ce || lamps.faultRelay))
      else $error("Latched fault dropped without a reset.");

   set_wins_a: assert property (ce && latchMode && faultStart && resetEvent |=> st.latched)
      else $error("Fault lost against a same-cycle reset.");

   lamp_mirror_a: assert property (lamps.faultLamp == lamps.faultRelay)
      else $error("Fault lamp does not mirror the relay.");

   nonlatch_relay_a: assert property (ce && !latchMode && defectSense && $stable(st.ctrl)
      |=> lamps.faultRelay)
      else $error("Non-latch relay idle while defect present.");

   setpoint_range_a: assert property (st.setpoint <= MAX_SETPOINT
      && st.setpoint % 16'h0064 == 16'h0000)
      else $error("Setpoint off the 100 V grid or above maximum.");

endmodule : spark_alarm_control

// File: design/spark_alarm_params.svh
`ifndef SPARK_ALARM_PARAMS_SVH
`define SPARK_ALARM_PARAMS_SVH

// Clock rate and time figures; cycle counts are derived in the module.
`define CLK_KHZ 50000
`define CLK_MHZ 50
`define DEBOUNCE_MS 20
`define SHOW_MS 1000
`define REPEAT_FIRST_MS 400
`define REPEAT_MIN_MS 50
`define MS_TICK_US 1000
`define PINHOLE_MAX_US 2000
`define PIN_SPACING_US 5000
`define GROSS_US 20000

// Voltage figures in volts, and the count wrap value.
`define SETPOINT_STEP_V 16'h0064
`define SETPOINT_MAX_V 20000
`define HV_LAMP_V 15'h01F4
`define COUNT_WRAP 10'h03E7

// Bit positions of the panel pin vector.
`define PIN_UP 0
`define PIN_DOWN 1
`define PIN_DISPLAY 2
`define PIN_COUNT_SHOW 3
`define PIN_COUNT_CLEAR 4
`define PIN_RESET 5
`define PIN_EXT_RESET_N 6
`define PIN_PERMIT_N 7
`define PIN_COVER 8

// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_HOLD 8'h04
`define REG_LIMITS 8'h08
`define REG_PERCENT 8'h0C
`define REG_STATUS 8'h10
`define REG_TOTAL 8'h14
`define REG_TYPES_A 8'h18
`define REG_TYPES_B 8'h1C
`define REG_SETPOINT 8'h20

// Control fields and reset values.
`define CTRL_LATCH 0
`define CTRL_REMOVE 1
`define CTRL_WD_PERCENT 2
`define CTRL_REDUCED 3
`define HOLD_RESET 16'h0064
`define HIGH_LIMIT_RESET 16'h4E20
`define PERCENT_RESET 7'h0A

`endif

// File: design/spark_alarm_pkg.sv
package spark_alarm_pkg;

   typedef logic [25:0] timer_type;

   typedef enum logic [1:0] {DISP_VOLTS, DISP_PERCENT, DISP_SETPOINT} disp_mode_type;

   typedef enum logic [2:0] {CNT_TOTAL, CNT_PIN, CNT_METAL, CNT_MULTI, CNT_GROSS} count_sel_type;

   // Operator buttons and contacts, as seen at the pins.
   typedef struct packed {
      logic coverLifted;
      logic highVoltagePermit_n;
      logic externalReset_n;
      logic resetButton;
      logic countClearButton;
      logic countDisplayButton;
      logic displayButton;
      logic downButton;
      logic upButton;
   } panel_pins_type;

   // Relay, lamp and generator drive.
   typedef struct packed {
      logic faultLamp;
      logic faultRelay;
      logic hvOnLamp;
      logic hvEnable;
      logic watchdogAlarm;
   } lamps_type;

endpackage : spark_alarm_pkg

// File: sim/panel_model.sv
`timescale 1ns/1ps
// Operator and contacts; an untouched button rests released, the permit loop stays closed.
module panel_model
   import spark_alarm_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Pins towards the block.
   output panel_pins_type pins
);
   // Permit grounded and reset contact open from the start.
   initial pins = 9'h040;

   // Sets one pin level just after an edge.
   task automatic setPin(input int idx, input logic v);
      @(posedge clk);
      pins[idx] <= v;
   endtask : setPin

   // Flips a pin for n cycles, then rests it as long, so both edges pass the filter.
   task automatic hold(input int idx, input int n);
      setPin(idx, ~pins[idx]);
      repeat (n) @(posedge clk);
      pins[idx] <= ~pins[idx];
      repeat (n) @(posedge clk);
   endtask : hold
endmodule : panel_model

// File: sim/test_spark_alarm_control.sv
`timescale 1ns/1ps
module test_spark_alarm_control
   import spark_alarm_pkg::*;
;
   logic clk, reset_n, ce, psel, penable, pwrite, pready, pslverr, rerr;
   logic defectSense, metalSense, serialReset, reducedSensitivity;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [14:0] measuredVolts;
   logic [6:0] percentLoad;
   logic [15:0] displayValue;
   logic [9:0] countValue;
   panel_pins_type panelPins;
   lamps_type lamps;
   disp_mode_type displayMode;
   count_sel_type countSelect;
   int mismatches = 0;
   int checksDone = 0;

   // Short panel timers keep the run brief; fault typing keeps its long defaults.
   spark_alarm_control #(.DEBOUNCE_CYCLES(26'h000_0004), .SHOW_CYCLES(26'h000_0014),
      .REPEAT_FIRST_CYCLES(26'h000_0028), .REPEAT_MIN_CYCLES(26'h000_0005),
      .MS_CYCLES(26'h000_0004)) uut (.clk, .reset_n, .ce, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .panelPins, .defectSense, .metalSense,
      .measuredVolts, .percentLoad, .serialReset, .lamps, .displayValue, .displayMode,
      .countValue, .countSelect, .reducedSensitivity);
   panel_model panel (.clk, .pins(panelPins));

   // Compares one value and reports a difference at once.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One APB transfer; the request stands until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // Reads a register and compares it.
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, exp, rdata);
   endtask : rd

   // A defect stays in the electrode for n cycles.
   task automatic defect(input int n);
      defectSense <= 1'b1;
      repeat (n) @(posedge clk);
      defectSense <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : defect

   // Prints the verdict and ends the run.
   task automatic close_out();
      if (mismatches == 0 && checksDone > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out

   // Clock of 20 ns period.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // A hang counts as a mismatch.
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out();
   end

   // Main sequence.
   initial
   begin
      {reset_n, psel, penable, pwrite, defectSense, metalSense, serialReset} = '0;
      ce = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      measuredVolts = 15'h0000;
      percentLoad = 7'h21;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd("ctrl", 8'h00, 32'h0000_0000);
      rd("hold", 8'h04, 32'h0000_0064);
      rd("limits", 8'h08, 32'h4E20_0000);
      rd("percent", 8'h0C, 32'h0000_000A);
      rd("unmapped", 8'h40, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, {31'h0, rerr});
      repeat (2) panel.hold(0, 10);
      rd("setpoint up", 8'h20, 32'h0000_00C8);
      repeat (3) panel.hold(1, 10);
      rd("setpoint floor", 8'h20, 32'h0000_0000);
      panel.hold(0, 100);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("held repeat", 32'h0000_0001, {31'h0, rdata > 32'h0000_0190});
      measuredVolts <= 15'h01F5;
      repeat (3) @(posedge clk);
      chk("hv lamp 501", 32'h0000_0001, {31'h0, lamps.hvOnLamp});
      measuredVolts <= 15'h03E8;
      repeat (3) @(posedge clk);
      chk("hv lamp 1000", 32'h0000_0001, {31'h0, lamps.hvOnLamp});
      chk("volts shown", 32'h0000_000A, {16'h0, displayValue});
      measuredVolts <= 15'h01F4;
      repeat (3) @(posedge clk);
      chk("hv lamp 500", 32'h0000_0000, {31'h0, lamps.hvOnLamp});
      panel.hold(2, 10);
      chk("percent mode", DISP_PERCENT, {30'h0, displayMode});
      chk("percent shown", 32'h0000_0021, {16'h0, displayValue});
      ce <= 1'b0;
      repeat (40) @(posedge clk);
      ce <= 1'b1;
      chk("frozen mode", DISP_PERCENT, {30'h0, displayMode});
      repeat (20) @(posedge clk);
      chk("setpoint mode", DISP_SETPOINT, {30'h0, displayMode});
      chk("setpoint shown", 32'h0000_0009, {16'h0, displayValue});
      repeat (40) @(posedge clk);
      chk("volts again", DISP_VOLTS, {30'h0, displayMode});
      chk("hv permitted", 32'h0000_0001, {31'h0, lamps.hvEnable});
      panel.setPin(8, 1'b1);
      repeat (12) @(posedge clk);
      chk("cover lifted", 32'h0000_0000, {31'h0, lamps.hvEnable});
      panel.setPin(8, 1'b0);
      panel.hold(7, 12);
      chk("permit back", 32'h0000_0001, {31'h0, lamps.hvEnable});
      apb(1'b1, 8'h00, 32'h0000_0001);
      defect(5);
      repeat (5) @(posedge clk);
      chk("latched relay", 32'h0000_0001, {31'h0, lamps.faultRelay});
      chk("latched lamp", 32'h0000_0001, {31'h0, lamps.faultLamp});
      chk("latch keeps hv", 32'h0000_0001, {31'h0, lamps.hvEnable});
      serialReset <= 1'b1;
      @(posedge clk);
      serialReset <= 1'b0;
      repeat (3) @(posedge clk);
      chk("serial reset", 32'h0000_0000, {31'h0, lamps.faultRelay});
      rd("total kept", 8'h14, 32'h0000_0001);
      apb(1'b1, 8'h00, 32'h0000_0003);
      defect(5);
      repeat (5) @(posedge clk);
      chk("removed hv", 32'h0000_0000, {31'h0, lamps.hvEnable});
      panel.hold(5, 10);
      chk("hv restored", 32'h0000_0001, {31'h0, lamps.hvEnable});
      chk("button reset", 32'h0000_0000, {31'h0, lamps.faultLamp});
      defect(5);
      panel.hold(6, 12);
      chk("contact reset", 32'h0000_0000, {31'h0, lamps.faultRelay});
      apb(1'b1, 8'h00, 32'h0000_0002);
      apb(1'b1, 8'h04, 32'h0000_0002);
      metalSense <= 1'b1;
      defect(5);
      metalSense <= 1'b0;
      chk("hold extends", 32'h0000_0001, {31'h0, lamps.faultRelay});
      chk("no removal", 32'h0000_0001, {31'h0, lamps.hvEnable});
      repeat (25) @(posedge clk);
      chk("hold ends", 32'h0000_0000, {31'h0, lamps.faultRelay});
      rd("total once", 8'h14, 32'h0000_0004);
      rd("types a", 8'h18, 32'h0001_0001);
      rd("types b", 8'h1C, 32'h0000_0002);
      apb(1'b1, 8'h08, 32'h4E20_03E8);
      rd("status", 8'h10, 32'h0000_0005);
      panel.hold(3, 10);
      chk("count sel", CNT_PIN, {29'h0, countSelect});
      chk("pin count", 32'h0000_0001, {22'h0, countValue});
      panel.hold(4, 10);
      rd("total cleared", 8'h14, 32'h0000_0000);
      rd("metal cleared", 8'h18, 32'h0000_0000);
      close_out();
   end
endmodule : test_spark_alarm_control
